// ==== tb_top.sv ====
// self-checking bench for the watchdog core
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys = 1'b0, resetn = 1'b0, jmp = 1'b0, ce = 1'b1;
	logic        io_wr, io_rd, sys_reset, irq11_n;
	logic [7:0]  io_addr, io_wdata, io_rdata, rv;
	logic [7:0]  ix[4] = '{8'h30, 8'hf5, 8'hf6, 8'hf7};
	logic [15:0] key[4] = '{16'h2e87, 16'h2e87, 16'h2e07, 16'h2f08};
	int          miscompares = 0, total_checks = 0, n, m[256];
	int unsigned seed = 74471;
	always #50 clk_sys = ~clk_sys;
	wdt_core #(.SEC_CYCLES(10)) dut_u (.clk_sys, .resetn, .ce, .io_addr, .io_wr, .io_rd,
		.io_wdata, .timeout_action_select_jumper(jmp), .io_rdata, .sys_reset, .irq11_n);
	wdt_host host_u (.clk_sys, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
	task automatic chk(input string s, input logic [7:0] v, input logic [7:0] e);
		total_checks++;
		if (v !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic end_sim();
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic put(input logic [7:0] i, input logic [7:0] d);
		m[i] = d;
		host_u.xfer(1'b0, 8'h2e, i, rv);
		host_u.xfer(1'b0, 8'h2f, d, rv);
	endtask
	task automatic get(input logic [7:0] i);
		host_u.xfer(1'b0, 8'h2e, i, rv);
		host_u.xfer(1'b1, 8'h2f, 8'h00, rv);
		chk("reg", rv, 8'(m[i]));
	endtask
	task automatic open_dev();
		foreach (key[k])
			host_u.xfer(1'b0, key[k][15:8], key[k][7:0], rv);
	endtask
	function automatic int unsigned xs(input int unsigned s);
		int unsigned r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction
	initial
	begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		host_u.xfer(1'b1, 8'h60, 8'h00, rv);
		chk("unmapped", rv, 8'h00);
		open_dev();
		foreach (ix[k]) get(ix[k]);
		host_u.xfer(1'b0, 8'h2e, 8'haa, rv);
		host_u.xfer(1'b1, 8'h2f, 8'h00, rv);
		chk("locked", rv, 8'h00);
		open_dev();
		put(8'h30, 8'h01);
		seed = xs(seed);
		n = seed % 4 + 1;
		put(8'hf6, 8'(n));
		t(n * 10 - 3);
		chk("rst", 8'(sys_reset), 8'h00);
		t(9);
		chk("rst", 8'(sys_reset), 8'h01);
		chk("irq", 8'(irq11_n), 8'h01);
		m[8'hf7] = 8'h10;
		get(8'hf7);
		put(8'hf6, 8'h00);
		t(2);
		chk("rst", 8'(sys_reset), 8'h00);
		put(8'hf5, 8'h08);
		jmp <= 1'b1;
		put(8'hf6, 8'h01);
		t(597);
		chk("irq", 8'(irq11_n), 8'h01);
		t(29);
		chk("irq", 8'(irq11_n), 8'h00);
		chk("rst", 8'(sys_reset), 8'h00);
		put(8'h30, 8'h00);
		put(8'hf5, 8'h00);
		put(8'hf6, 8'h02);
		t(40);
		chk("irq", 8'(irq11_n), 8'h01);
		get(8'hf6);
		put(8'h30, 8'h01);
		put(8'hf6, 8'h02);
		t(10);
		ce <= 1'b0;
		t(30);
		ce <= 1'b1;
		t(9);
		chk("irq", 8'(irq11_n), 8'h01);
		t(5);
		chk("irq", 8'(irq11_n), 8'h00);
		end_sim();
	end
	initial
	begin
		#400000;
		miscompares++;
		end_sim();
	end
endmodule // tb_top

// ==== wdt_chk_props.sv ====
// port checks for the watchdog core
`timescale 1ns/1ps
module wdt_chk (
	input logic       clk_sys,   // clock
	input logic       resetn,    // reset
	input logic [7:0] io_addr,   // address
	input logic       io_wr,     // write
	input logic       io_rd,     // read
	input logic       timeout_action_select_jumper, // route
	input logic [7:0] io_rdata,  // data
	input logic       sys_reset, // reset out
	input logic       irq11_n    // irq out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// a data port write may clear the flag; the outputs follow one cycle later
	wire dwr = io_wr && io_addr == 8'h2f;
	chk_one_act: assert property (!(sys_reset && !irq11_n)) else $error("two actions");
	chk_rst_route: assert property (sys_reset |-> !timeout_action_select_jumper) else $error("route");
	chk_irq_route: assert property (!irq11_n |-> timeout_action_select_jumper) else $error("route");
	chk_irq_hold: assert property (!irq11_n && !dwr && !$past(dwr) |=> !irq11_n) else $error("irq drop");
	chk_rst_hold: assert property (sys_reset && !dwr && !$past(dwr) |=> sys_reset) else $error("rst drop");
	chk_rd_idle: assert property (!$past(io_rd) |-> io_rdata == 8'h00) else $error("stray");
	chk_addr_dec: assert property (io_rd && io_addr[7:1] != 7'h17 |=> io_rdata == 8'h00) else $error("dec");
	chk_rst_state: assert property ($rose(resetn) |-> !sys_reset && irq11_n) else $error("init");
endmodule // wdt_chk
bind wdt_core wdt_chk chk_u (.clk_sys, .resetn, .io_addr, .io_wr, .io_rd,
	.timeout_action_select_jumper, .io_rdata, .sys_reset, .irq11_n);

// ==== wdt_consts.svh ====
// register indices, keys, field positions and timing counts for the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_ADDR_INDEX      8'h2e
`define WDT_ADDR_DATA       8'h2f
`define WDT_KEY_UNLOCK      8'h87
`define WDT_KEY_LOCK        8'haa
`define WDT_IDX_DEVSEL      8'h07
`define WDT_IDX_ACTIVE      8'h30
`define WDT_IDX_UNIT        8'hf5
`define WDT_IDX_COUNT       8'hf6
`define WDT_IDX_STATUS      8'hf7
`define WDT_DEV_WATCHDOG    8'h08
`define WDT_UNIT_BIT        3
`define WDT_STAT_FORCE_BIT  5
`define WDT_STAT_TOUT_BIT   4
`define WDT_ACT_BIT         0
`define WDT_CLK_HZ          10000000
`define WDT_SEC_CYCLES      (`WDT_CLK_HZ * 1)
`define WDT_SEC_PER_MIN     60
`endif

// ==== wdt_core.sv ====
// watchdog timer behind an index/data port pair
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_core
	import wdt_pkg::*;
#(
	parameter int SEC_CYCLES = `WDT_SEC_CYCLES
) (
	input  wire logic       clk_sys,        // system clock, 10 MHz
	input  wire logic       resetn,         // synchronous reset, active low
	input  wire logic       ce,             // clock enable, freezes all state when low
	input  wire logic [7:0] io_addr,        // i/o address low byte
	input  wire logic       io_wr,          // write strobe, one cycle
	input  wire logic       io_rd,          // read strobe, one cycle
	input  wire logic [7:0] io_wdata,       // write data
	input  wire logic       timeout_action_select_jumper, // 1 interrupt, 0 reset (pin)
	output logic [7:0]      io_rdata,       // read data, valid cycle after io_rd
	output logic            sys_reset,      // system reset request, active high
	output logic            irq11_n         // interrupt 11, active low level
);
	logic        jmp_s1_q;
	logic        jmp_q;
	wdt_lock_t   lock_q;
	logic [7:0]  idx_q;
	logic [7:0]  ldn_q;
	logic        act_q;
	logic        unit_q;
	logic [7:0]  cnt_q;
	logic        tout_q;
	logic        sec_tick;
	logic        min_tick;

	wire sel_idx  = (io_addr == `WDT_ADDR_INDEX);
	wire sel_dat  = (io_addr == `WDT_ADDR_DATA);
	wire wr_idx   = ce && io_wr && sel_idx;
	wire open_cfg = (lock_q == WDT_OPEN);
	wire key_open = (io_wdata == `WDT_KEY_UNLOCK);
	wire key_shut = (io_wdata == `WDT_KEY_LOCK);
	// index is latched only once open, and never from the lock key itself
	wire idx_lat  = wr_idx && open_cfg && !key_shut;
	// data port reaches the register named by the last index latched while open
	wire wr_dat   = ce && io_wr && sel_dat && open_cfg;
	// watchdog group is visible only while its device number is selected
	wire in_wdt   = (ldn_q == `WDT_DEV_WATCHDOG);
	// register hits on the latched index
	wire hit_ldn  = (idx_q == `WDT_IDX_DEVSEL);
	wire hit_act  = in_wdt && (idx_q == `WDT_IDX_ACTIVE);
	wire hit_unit = in_wdt && (idx_q == `WDT_IDX_UNIT);
	wire hit_cnt  = in_wdt && (idx_q == `WDT_IDX_COUNT);
	wire hit_stat = in_wdt && (idx_q == `WDT_IDX_STATUS);
	wire wr_ldn   = wr_dat && hit_ldn;
	wire wr_act   = wr_dat && hit_act;
	wire wr_unit  = wr_dat && hit_unit;
	wire wr_cnt   = wr_dat && hit_cnt;
	wire wr_stat  = wr_dat && hit_stat;
	// the force bit is not stored, so it always reads back as zero
	wire force_to = wr_stat && io_wdata[`WDT_STAT_FORCE_BIT];
	wire unit_tick = unit_q ? min_tick : sec_tick;
	wire running   = act_q && (cnt_q != 8'h00) && !tout_q;
	wire expire    = running && unit_tick && (cnt_q == 8'h01);
	// ticks are registered, so a tick frozen by ce must not be counted again
	wire dec_cnt   = ce && running && unit_tick;
	// a clear in the same cycle as an expiry loses, so a late reload cannot hide a timeout
	wire tout_set  = ce && act_q && (expire || force_to);
	wire tout_clr  = wr_cnt || (wr_act && !io_wdata[`WDT_ACT_BIT]);
	// status: only the timeout flag is implemented
	wire [7:0] stat_rd = {2'b00, 1'b0, tout_q, 4'h0};

	// read mux; unknown indices and unimplemented bits read as zero
	wire [7:0] reg_rd =
		hit_ldn  ? ldn_q :
		hit_act  ? {7'h00, act_q} :
		hit_unit ? {4'h0, unit_q, 3'h0} :
		hit_cnt  ? cnt_q :
		hit_stat ? stat_rd : 8'h00;
	// a locked data port reads zero, so probing it reveals nothing
	wire       rd_hit = ce && io_rd && sel_dat && open_cfg;
	wire [7:0] rd_d   = rd_hit ? reg_rd : 8'h00;

	// timebase restarts on a count write, so the first unit is always a full one
	wdt_tick #(
		.SEC_CYCLES (SEC_CYCLES)
	) u_tick (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.ce       (ce),
		.clear    (wr_cnt),
		.sec_tick (sec_tick),
		.min_tick (min_tick)
	);

	// jumper pin passes two flops before use; it is meant to be static
	// the flops only keep a jumper moved under power from upsetting the routing
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			jmp_s1_q <= 1'b0;
			jmp_q    <= 1'b0;
		end
		else if (ce)
		begin
			jmp_s1_q <= timeout_action_select_jumper;
			jmp_q    <= jmp_s1_q;
		end
	end

	// unlock needs two consecutive keys; any other index write restarts it
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			lock_q <= WDT_LOCKED;
		else if (wr_idx)
		begin
			unique case (lock_q)
				WDT_LOCKED: lock_q <= key_open ? WDT_HALF : WDT_LOCKED;
				WDT_HALF:   lock_q <= key_open ? WDT_OPEN : WDT_LOCKED;
				WDT_OPEN:   lock_q <= key_shut ? WDT_LOCKED : WDT_OPEN;
				// the unused code is illegal and falls back to locked
				default:    lock_q <= WDT_LOCKED;
			endcase
		end
	end

	// index register, written only through idx_lat
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			idx_q <= 8'h00;
		else if (idx_lat)
			idx_q <= io_wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			ldn_q  <= 8'h00;
			act_q  <= 1'b0;
			unit_q <= 1'b0;
		end
		else if (ce)
		begin
			// another device group may be selected; it only hides the watchdog registers
			if (wr_ldn)
				ldn_q <= io_wdata;
			if (wr_act)
				act_q <= io_wdata[`WDT_ACT_BIT];
			if (wr_unit)
				unit_q <= io_wdata[`WDT_UNIT_BIT];
		end
	end

	// a full byte, so 1 to 255 units; zero parks the timer
	// count reload; write also clears timeout, which resets the watchdog
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			cnt_q <= 8'h00;
		else if (wr_cnt)
			cnt_q <= io_wdata;
		// one step down per selected unit tick
		else if (dec_cnt)
			cnt_q <= cnt_q - 8'h01;
	end

	// sticky timeout flag; a new expiry beats the clearing reload
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			tout_q <= 1'b0;
		else if (tout_set)
			tout_q <= 1'b1;
		else if (tout_clr)
			tout_q <= 1'b0;
	end

	// reset request only when the jumper picks reset
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			sys_reset <= 1'b0;
		else if (ce)
			sys_reset <= tout_q && !jmp_q;
	end

	// interrupt is a level that stands low for as long as the flag does
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			irq11_n <= 1'b1;
		else if (ce)
			irq11_n <= !(tout_q && jmp_q);
	end

	// read data stands for the one cycle after the read strobe
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			io_rdata <= 8'h00;
		else if (ce)
			io_rdata <= rd_d;
	end
endmodule // wdt_core

// ==== wdt_host.sv ====
// host model for the index and data ports
`timescale 1ns/1ps
module wdt_host (
	input  logic       clk_sys,         // clock
	output logic [7:0] io_addr = 8'h00, // address
	output logic       io_wr = 1'b0,    // write
	output logic       io_rd = 1'b0,    // read
	output logic [7:0] io_wdata = 8'h00,// data out
	input  logic [7:0] io_rdata         // data in
);
	// one access per call: address, data and a single one-cycle read or write strobe, all driven on the same edge
	task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		io_addr <= a;
		io_wdata <= d;
		io_rd <= r;
		io_wr <= !r;
		@(posedge clk_sys);
		io_rd <= 1'b0;
		io_wr <= 1'b0;
		// released data is not left standing
		io_wdata <= ~d;
		#1 q = io_rdata;
	endtask
endmodule // wdt_host

// ==== wdt_pkg.sv ====
// types used by the watchdog core
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_LOCKED = 2'b00,
		WDT_HALF   = 2'b01,
		WDT_OPEN   = 2'b11
	} wdt_lock_t;
endpackage

// ==== wdt_tick.sv ====
// timebase: one-cycle ticks per second and per minute
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_tick #(
	parameter int SEC_CYCLES = `WDT_SEC_CYCLES
) (
	input  wire logic clk_sys,   // system clock
	input  wire logic resetn,    // synchronous reset, active low
	input  wire logic ce,        // clock enable
	input  wire logic clear,     // restart timebase phase
	output logic      sec_tick,  // one pulse per second
	output logic      min_tick   // one pulse per minute
);
	logic [31:0] cyc_q;
	logic [5:0]  sec_q;
	wire         sec_end = (cyc_q == 32'(SEC_CYCLES - 1));
	wire         min_end = sec_end && (sec_q == 6'(`WDT_SEC_PER_MIN - 1));

	always_ff @(posedge clk_sys)
	begin
		if (!resetn || (ce && clear))
		begin
			cyc_q    <= 32'h0;
			sec_q    <= 6'h0;
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
		end
		else if (ce)
		begin
			cyc_q    <= sec_end ? 32'h0 : cyc_q + 32'h1;
			sec_q    <= min_end ? 6'h0 : (sec_end ? sec_q + 6'h1 : sec_q);
			sec_tick <= sec_end;
			min_tick <= min_end;
		end
	end
endmodule // wdt_tick
